// ### hw/mdp_fifo.sv
// Byte FIFO with flush; a flush and a push together leave only the pushed byte
`timescale 1ns/1ps
module mdp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = mdp_pkg::FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [W-1:0] i_data,
  input wire logic i_pop,
  output logic [W-1:0] o_data,
  output logic [$clog2(DEPTH):0] o_count,
  output logic o_full,
  output logic o_empty
);
  import mdp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] count;
  } mdp_fifo_state_t;

  mdp_fifo_state_t q;
  mdp_fifo_state_t d;
  logic push_ok;
  logic pop_ok;
  logic [AW-1:0] wr_base;
  logic [AW:0] cnt_base;

  always_comb
  begin
    d = q;
    push_ok = i_push && (i_flush || !o_full);
    pop_ok = i_pop && !o_empty && !i_flush;
    wr_base = i_flush ? '0 : q.wr;
    cnt_base = i_flush ? '0 : q.count;
    d.rd = i_flush ? '0 : AW'(q.rd + AW'(pop_ok));
    d.wr = AW'(wr_base + AW'(push_ok));
    if (push_ok)
      d.mem[wr_base] = i_data;
    d.count = (AW + 1)'(cnt_base + (AW + 1)'(push_ok) - (AW + 1)'(pop_ok));
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  assign o_data = q.mem[q.rd];
  assign o_count = q.count;
  assign o_full = (q.count == (AW + 1)'(DEPTH));
  assign o_empty = (q.count == '0);

endmodule : mdp_fifo

// ### hw/mdp_port.sv
// MIDI serial port: command interpreter, mode control, buffers and status
`timescale 1ns/1ps
module mdp_port #(
  parameter int DEPTH = mdp_pkg::FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_out_wr,
  input wire logic [7:0] i_out_byte,
  input wire logic i_in_rd,
  output logic [7:0] o_in_byte,
  input wire logic i_cmd_wr,
  input wire logic [7:0] i_cmd_byte,
  input wire logic i_stat_rd,
  output logic [7:0] o_port_status,
  input wire logic [7:0] i_port_control,
  input wire logic i_wide_window,
  input wire logic i_pt_fifo_en,
  input wire logic i_serial_in_line,
  output logic o_serial_out_line,
  output logic o_irq
);
  import mdp_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic uart;
    logic block;
    logic overrun;
    mdp_cmd_state_t cst;
    logic [7:0] cmd;
    logic [7:0] resp;
    logic [7:0] in_byte;
    logic [7:0] status;
    logic irq;
  } mdp_port_state_t;

  mdp_port_state_t q;
  mdp_port_state_t d;

  mdp_byte_if bus ();

  logic [7:0] ctrl;
  logic [8:0] reply;
  logic fifo_on;
  logic rx_cap_full;
  logic rx_in;
  logic rx_take;
  logic exec;
  logic ack_push;
  logic data_push;
  logic rx_push;
  logic [7:0] rx_push_data;
  logic rx_pop;
  logic flush_rx;
  logic flush_tx;
  logic tx_push;
  logic tx_pop;
  logic [7:0] rx_head;
  logic [7:0] tx_head;
  logic [CW-1:0] rx_count;
  logic [CW-1:0] tx_count;
  logic rx_full;
  logic rx_empty;
  logic tx_full;
  logic tx_empty;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath decode
  // A legacy two-byte window cannot reach the control register
  assign ctrl = i_wide_window ? i_port_control : CTRL_RESET;
  assign reply = mdp_cmd_reply(q.cmd);
  assign fifo_on = q.uart | i_pt_fifo_en;
  // Without the FIFO, Pass-Thru keeps a single-byte receive buffer
  assign rx_cap_full = fifo_on ? rx_full : !rx_empty;
  assign rx_in = bus.rx_valid;
  assign rx_take = rx_in && !q.block && !rx_cap_full;
  assign exec = (q.cst == CMD_WAIT) && !bus.tx_busy && !bus.rx_busy;
  assign ack_push = exec && !q.uart;
  assign data_push = (q.cst == CMD_DATA) && !rx_in;
  assign rx_push = rx_take | ack_push | data_push;
  assign rx_push_data = rx_take ? bus.rx_data : (ack_push ? REPLY_ACK : q.resp);
  assign rx_pop = i_in_rd && !rx_empty;
  assign flush_rx = exec && ((!q.uart && q.cmd == CMD_UART && !i_pt_fifo_en)
    || (q.cmd == CMD_RESET && (!q.uart || !i_pt_fifo_en)));
  assign flush_tx = exec && (q.cmd == CMD_RESET);
  // Pass-Thru transmit holds one byte and only with the enable bit set
  assign tx_push = i_out_wr && !flush_tx
    && (q.uart ? !tx_full : (ctrl[CT_PT_TX] && tx_empty));
  assign bus.tx_valid = !tx_empty && !flush_tx;
  assign bus.tx_data = tx_head;
  assign tx_pop = bus.tx_valid && bus.tx_ready;

  mdp_fifo #(.W(8), .DEPTH(DEPTH)) u_rx_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_flush(flush_rx),
    .i_push(rx_push),
    .i_data(rx_push_data),
    .i_pop(rx_pop),
    .o_data(rx_head),
    .o_count(rx_count),
    .o_full(rx_full),
    .o_empty(rx_empty)
  );

  mdp_fifo #(.W(8), .DEPTH(DEPTH)) u_tx_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_flush(flush_tx),
    .i_push(tx_push),
    .i_data(i_out_byte),
    .i_pop(tx_pop),
    .o_data(tx_head),
    .o_count(tx_count),
    .o_full(tx_full),
    .o_empty(tx_empty)
  );

  mdp_serial_engine u_engine (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_serial_in_line(i_serial_in_line),
    .o_serial_out_line(o_serial_out_line),
    .bus(bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command interpreter, flags and status
  always_comb
  begin
    d = q;
    if (i_in_rd)
      d.in_byte = rx_head;
    if (rx_pop)
      d.block = 1'b0;
    if (i_stat_rd)
      d.overrun = 1'b0;
    case (q.cst)
      CMD_IDLE:
      begin
        if (i_cmd_wr)
        begin
          d.cmd = i_cmd_byte;
          d.cst = CMD_WAIT;
        end
      end
      CMD_WAIT:
      begin
        if (exec)
        begin
          d.cst = CMD_IDLE;
          if (!q.uart)
          begin
            if (reply[8])
            begin
              d.resp = reply[7:0];
              d.cst = CMD_DATA;
            end
            if (q.cmd == CMD_UART)
            begin
              d.uart = 1'b1;
              d.block = !i_pt_fifo_en;
            end
            else if (q.cmd == CMD_RESET)
            begin
              d.overrun = 1'b0;
              d.block = 1'b0;
            end
          end
          else if (q.cmd == CMD_RESET)
          begin
            d.uart = 1'b0;
            d.overrun = 1'b0;
            d.block = 1'b0;
          end
        end
      end
      CMD_DATA:
      begin
        if (!rx_in)
          d.cst = CMD_IDLE;
      end
      default:
        d.cst = CMD_IDLE;
    endcase
    // A new overrun wins over a clearing status read
    if (rx_in && !q.block && rx_cap_full)
      d.overrun = 1'b1;
    d.status = 8'h00;
    d.status[ST_RX_EMPTY] = rx_empty;
    d.status[ST_TX_FULL] = q.uart ? tx_full : !tx_empty;
    d.status[ST_RX_FULL] = fifo_on && rx_full;
    d.status[ST_MODE] = q.uart;
    d.status[ST_OVERRUN] = q.overrun;
    d.status[ST_TX_EMPTY] = fifo_on && tx_empty;
    d.irq = (ctrl[CT_RX_IRQ] && (q.uart ? (rx_count >= CW'(RX_IRQ_LEVEL)) : !rx_empty))
      || (ctrl[CT_TX_IRQ] && tx_empty && (q.uart || ctrl[CT_PT_TX]));
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      q <= '0;
      q.status <= 8'h80;
    end
    else
      q <= d;
  end

  assign o_in_byte = q.in_byte;
  assign o_port_status = q.status;
  assign o_irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_exec_pt(logic [7:0] c);
    exec && !q.uart && q.cmd == c;
  endsequence

  sequence s_ack_then(logic [7:0] v);
    (rx_push && rx_push_data == REPLY_ACK) ##1 (!rx_in) ##0 (rx_push && rx_push_data == v);
  endsequence

  a_reset_passthru: assert property ($past(i_rst) |-> !q.uart && q.cst == CMD_IDLE)
    else $error("port not in Pass-Thru after reset");
  a_pt_write_drop: assert property (!q.uart && !ctrl[CT_PT_TX] && i_out_wr |=> tx_empty)
    else $error("Pass-Thru write stored while transmit disabled");
  a_uart_entry: assert property (s_exec_pt(CMD_UART) ##0 (!i_pt_fifo_en && !i_in_rd)
    |=> q.uart && rx_count == CW'(1) && q.block)
    else $error("3Fh did not enter UART with one ack");
  a_ack_version: assert property (s_exec_pt(CMD_VER) |-> s_ack_then(REPLY_VER))
    else $error("ACh reply sequence wrong");
  a_cmd_defer: assert property (q.cst == CMD_WAIT && (bus.tx_busy || bus.rx_busy)
    |-> !rx_push || rx_take ##1 q.cst == CMD_WAIT)
    else $error("command ran during a byte transfer");
  a_rx_overrun: assert property (rx_in && !q.block && rx_cap_full |=> q.overrun && $stable(rx_count))
    else $error("overrun byte stored or flag missed");
  a_uart_ignore: assert property (exec && q.uart && q.cmd != CMD_RESET && !i_in_rd
    |=> q.uart && $stable(rx_count))
    else $error("UART command not ignored");
  a_status_mode: assert property (##1 o_port_status[ST_MODE] == $past(q.uart))
    else $error("mode bit mismatch");

endmodule : mdp_port

// ### hw/mdp_serial_engine.sv
// Serialiser and deserialiser: 1 start, 8 data LSB first, 1 stop, no parity
`timescale 1ns/1ps
module mdp_serial_engine (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_serial_in_line,
  output logic o_serial_out_line,
  mdp_byte_if.eng bus
);
  import mdp_pkg::*;

  typedef struct packed {
    logic [7:0] div;
    logic tick;
    logic tx_on;
    logic [3:0] tx_os;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic tx_line;
    logic rx_on;
    logic rx_prev;
    logic [3:0] rx_os;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_valid;
  } mdp_eng_state_t;

  mdp_eng_state_t q;
  mdp_eng_state_t d;

  always_comb
  begin
    d = q;
    d.rx_valid = 1'b0;
    // Oversampling tick, 16 per bit time
    d.tick = (q.div == TICK_LAST);
    d.div = d.tick ? 8'h00 : 8'(q.div + 8'h01);
    if (!q.tx_on && bus.tx_valid)
    begin
      d.tx_on = 1'b1;
      d.tx_sh = {1'b1, bus.tx_data, 1'b0};
      d.tx_os = 4'h0;
      d.tx_bit = 4'h0;
      d.tx_line = 1'b0;
    end
    else if (q.tx_on && q.tick)
    begin
      d.tx_os = 4'(q.tx_os + 4'h1);
      if (q.tx_os == OS_LAST)
      begin
        d.tx_sh = {1'b1, q.tx_sh[9:1]};
        d.tx_bit = 4'(q.tx_bit + 4'h1);
        d.tx_line = q.tx_sh[1];
        if (q.tx_bit == FRAME_LAST)
        begin
          d.tx_on = 1'b0;
          d.tx_line = 1'b1;
        end
      end
    end
    d.rx_prev = i_serial_in_line;
    if (!q.rx_on)
    begin
      if (q.rx_prev && !i_serial_in_line)
      begin
        d.rx_on = 1'b1;
        d.rx_os = 4'h0;
        d.rx_bit = 4'h0;
      end
    end
    else if (q.tick)
    begin
      d.rx_os = 4'(q.rx_os + 4'h1);
      if (q.rx_os == SAMPLE_POINT)
      begin
        d.rx_bit = 4'(q.rx_bit + 4'h1);
        // A start bit that is high again at its centre was a glitch
        if (q.rx_bit == 4'h0)
          d.rx_on = !i_serial_in_line;
        else if (q.rx_bit == FRAME_LAST)
        begin
          d.rx_on = 1'b0;
          d.rx_valid = i_serial_in_line;
        end
        else
          d.rx_sh = {i_serial_in_line, q.rx_sh[7:1]};
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      q <= '0;
      q.tx_line <= 1'b1;
      q.rx_prev <= 1'b1;
    end
    else
      q <= d;
  end

  assign o_serial_out_line = q.tx_line;
  assign bus.tx_ready = !q.tx_on;
  assign bus.tx_busy = q.tx_on;
  assign bus.rx_valid = q.rx_valid;
  assign bus.rx_data = q.rx_sh;
  // Busy covers the delivery cycle so a command cannot slip in beside it
  assign bus.rx_busy = q.rx_on | q.rx_valid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  a_tx_start_low: assert property (!q.tx_on && bus.tx_valid |=> !o_serial_out_line [*8])
    else $error("start bit not driven low");
  a_tx_idle_high: assert property (!q.tx_on && !$past(q.tx_on) |-> o_serial_out_line)
    else $error("idle line not high");
  a_tick_spacing: assert property (q.tick |=> !q.tick [*8])
    else $error("oversample tick too frequent");

endmodule : mdp_serial_engine

// ### shared/mdp_byte_if.sv
// Byte hand-over between the port controller and the serial engine
`timescale 1ns/1ps
interface mdp_byte_if;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_busy;
  modport eng (input tx_valid, input tx_data, output tx_ready, output tx_busy,
    output rx_valid, output rx_data, output rx_busy);
  modport ctl (output tx_valid, output tx_data, input tx_ready, input tx_busy,
    input rx_valid, input rx_data, input rx_busy);
endinterface : mdp_byte_if

// ### shared/mdp_pkg.sv
// Shared constants, types and helpers for the MIDI serial port
package mdp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLOCK_HZ = 125_000_000;
  localparam int unsigned BIT_RATE_BPS = 31_250;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ / (BIT_RATE_BPS * OVERSAMPLE);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
  localparam logic [3:0] OS_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] SAMPLE_POINT = 4'(OVERSAMPLE / 2 - 1);
  localparam int unsigned FRAME_BITS = 10;
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Buffers
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned RX_IRQ_LEVEL = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Port status register bits
  localparam int unsigned ST_RX_EMPTY = 7;
  localparam int unsigned ST_TX_FULL = 6;
  localparam int unsigned ST_RX_FULL = 5;
  localparam int unsigned ST_MODE = 4;
  localparam int unsigned ST_OVERRUN = 3;
  localparam int unsigned ST_TX_EMPTY = 2;

  // Port control register bits and the value used for a legacy window
  localparam int unsigned CT_TX_IRQ = 1;
  localparam int unsigned CT_RX_IRQ = 3;
  localparam int unsigned CT_PT_TX = 4;
  localparam logic [7:0] CTRL_RESET = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Commands and replies
  localparam logic [7:0] CMD_UART = 8'h3F;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_VER = 8'hAC;
  localparam logic [7:0] CMD_REV = 8'hAD;
  localparam logic [7:0] CMD_TEMPO = 8'hAF;
  localparam logic [7:0] CMD_QUERY = 8'hAB;
  localparam logic [7:0] REPLY_ACK = 8'hFE;
  localparam logic [7:0] REPLY_ZERO = 8'h00;
  localparam logic [7:0] REPLY_VER = 8'h15;
  localparam logic [7:0] REPLY_REV = 8'h01;
  localparam logic [7:0] REPLY_TEMPO = 8'h64;

  typedef enum logic [1:0] {CMD_IDLE, CMD_WAIT, CMD_DATA} mdp_cmd_state_t;

  // Bit 8 set when a data byte follows the acknowledge
  function automatic logic [8:0] mdp_cmd_reply(input logic [7:0] cmd);
    logic [8:0] r;
    r = {1'b0, REPLY_ZERO};
    if (cmd[7:3] == 5'h14 || cmd == CMD_QUERY)
      r = {1'b1, REPLY_ZERO};
    else if (cmd == CMD_VER)
      r = {1'b1, REPLY_VER};
    else if (cmd == CMD_REV)
      r = {1'b1, REPLY_REV};
    else if (cmd == CMD_TEMPO)
      r = {1'b1, REPLY_TEMPO};
    return r;
  endfunction : mdp_cmd_reply

endpackage : mdp_pkg

// ### verif/mdp_midi_dev.sv
// Behavioural far-side MIDI device: sends frames into the port and decodes its output
`timescale 1ns/1ps
module mdp_midi_dev (
  input wire logic i_clock,
  input wire logic i_serial_out_line,
  output logic o_serial_in_line,
  output logic [7:0] o_got,
  output logic o_got_stop,
  output int o_got_n
);
  import mdp_pkg::*;
  localparam int BIT = TICK_CYCLES * OVERSAMPLE;

  ////////////////////////////////////////////////////////////////////////////
  // Line idles high, as the pull-up holds it with no traffic
  initial
  begin
    o_serial_in_line = 1'b1;
    o_got = 8'h00;
    o_got_stop = 1'b0;
    o_got_n = 0;
  end

  task automatic send_byte(input logic [7:0] b);
    @(posedge i_clock);
    o_serial_in_line <= 1'b0;
    repeat (BIT) @(posedge i_clock);
    for (int i = 0; i < 8; i++)
    begin
      o_serial_in_line <= b[i];
      repeat (BIT) @(posedge i_clock);
    end
    o_serial_in_line <= 1'b1;
    repeat (BIT) @(posedge i_clock);
  endtask : send_byte

  ////////////////////////////////////////////////////////////////////////////
  // Samples mid-bit so edge jitter of a few cycles does not matter
  initial
  begin
    logic [7:0] b;
    forever
    begin
      @(negedge i_serial_out_line);
      repeat (BIT / 2) @(posedge i_clock);
      if (i_serial_out_line === 1'b0)
      begin
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT) @(posedge i_clock);
          b[i] = i_serial_out_line;
        end
        repeat (BIT) @(posedge i_clock);
        o_got_stop = i_serial_out_line;
        o_got = b;
        o_got_n = o_got_n + 1;
      end
    end
  end
endmodule : mdp_midi_dev

// ### verif/midi_serial_port_test.sv
// Self-checking bench of the MIDI serial port with a far-side device model
`timescale 1ns/1ps
module midi_serial_port_test;
  import mdp_pkg::*;
  logic i_clock, i_rst, i_out_wr, i_in_rd, i_cmd_wr, i_stat_rd;
  logic [7:0] i_out_byte, i_cmd_byte, i_port_control, o_in_byte, o_port_status, got, v;
  logic i_wide_window, i_pt_fifo_en, o_irq, got_stop;
  wire logic ser_in, ser_out;
  int fails, checked, got_n, seed;
  logic [7:0] tx_b [17];
  logic [7:0] cmds [13];
  logic [7:0] rx_b;
  logic [8:0] e;

  mdp_port u_mdp_port (.i_clock(i_clock), .i_rst(i_rst), .i_out_wr(i_out_wr), .i_out_byte(i_out_byte),
    .i_in_rd(i_in_rd), .o_in_byte(o_in_byte), .i_cmd_wr(i_cmd_wr), .i_cmd_byte(i_cmd_byte),
    .i_stat_rd(i_stat_rd), .o_port_status(o_port_status), .i_port_control(i_port_control),
    .i_wide_window(i_wide_window), .i_pt_fifo_en(i_pt_fifo_en), .i_serial_in_line(ser_in),
    .o_serial_out_line(ser_out), .o_irq(o_irq));
  mdp_midi_dev u_mdp_midi_dev (.i_clock(i_clock), .i_serial_out_line(ser_out), .o_serial_in_line(ser_in),
    .o_got(got), .o_got_stop(got_stop), .o_got_n(got_n));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Bit 8 tells that a data byte follows the acknowledge
  function automatic logic [8:0] exp_reply(input logic [7:0] c);
    case (c)
      8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAB: return 9'h100;
      8'hAC: return 9'h115;
      8'hAD: return 9'h101;
      8'hAF: return 9'h164;
      default: return 9'h000;
    endcase
  endfunction : exp_reply

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : cyc

  task automatic cmd(input logic [7:0] b);
    @(posedge i_clock);
    i_cmd_wr <= 1'b1;
    i_cmd_byte <= b;
    @(posedge i_clock);
    i_cmd_wr <= 1'b0;
    cyc(6);
  endtask : cmd

  task automatic rd(output logic [7:0] b);
    @(posedge i_clock);
    i_in_rd <= 1'b1;
    @(posedge i_clock);
    i_in_rd <= 1'b0;
    #1 b = o_in_byte;
    cyc(3);
  endtask : rd

  task automatic wr_burst(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clock);
      i_out_wr <= 1'b1;
      i_out_byte <= tx_b[i];
    end
    @(posedge i_clock);
    i_out_wr <= 1'b0;
    cyc(4);
  endtask : wr_burst

  ////////////////////////////////////////////////////////////////////////////
  // Frames take 40000 cycles each; the run needs about 85000
  initial
  begin
    repeat (100000) @(posedge i_clock);
    fails++;
    final_report();
  end

  initial
  begin
    seed = 91746;
    {i_out_wr, i_in_rd, i_cmd_wr, i_stat_rd} <= 4'h0;
    {i_out_byte, i_cmd_byte} <= 16'h0000;
    i_port_control <= 8'($random(seed)) & 8'hEF;
    i_wide_window <= 1'b1;
    i_pt_fifo_en <= 1'b1;
    i_rst <= 1'b1;
    for (int i = 0; i < 17; i++)
      tx_b[i] = 8'($random(seed));
    rx_b = 8'($random(seed));
    for (int i = 0; i < 8; i++)
      cmds[i] = 8'hA0 + 8'(i);
    cmds[8] = 8'hAB;
    cmds[9] = 8'hAC;
    cmds[10] = 8'hAD;
    cmds[11] = 8'hAF;
    cmds[12] = 8'($random(seed)) & 8'h7F;
    if (cmds[12] == CMD_UART)
      cmds[12] = 8'h12;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    cyc(3);
    chk(o_port_status, 8'h84);
    chk(ser_out, 1'b1);
    wr_burst(1);
    cyc(20);
    chk(ser_out, 1'b1);
    chk(o_port_status[ST_TX_EMPTY], 1'b1);
    // Every reply kind, with a random undefined command last
    for (int i = 0; i < 13; i++)
    begin
      cmd(cmds[i]);
      chk(o_port_status[ST_RX_EMPTY], 1'b0);
      chk(o_irq, i_port_control[CT_RX_IRQ]);
      e = exp_reply(cmds[i]);
      rd(v);
      chk(v, REPLY_ACK);
      if (e[8])
      begin
        rd(v);
        chk(v, e[7:0]);
      end
      chk(o_port_status[ST_RX_EMPTY], 1'b1);
      chk(o_irq, 1'b0);
    end
    // Sixteen reply bytes fill the receive FIFO, the next pair is lost; only serial bytes flag overrun
    for (int i = 0; i < 8; i++)
      cmd(CMD_VER);
    cmd(CMD_REV);
    chk(o_port_status, 8'h24);
    @(posedge i_clock);
    i_stat_rd <= 1'b1;
    @(posedge i_clock);
    i_stat_rd <= 1'b0;
    cyc(3);
    chk(o_port_status[ST_OVERRUN], 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      rd(v);
      chk(v, i[0] ? REPLY_VER : REPLY_ACK);
    end
    cmd(CMD_VER);
    cmd(CMD_RESET);
    rd(v);
    chk(v, REPLY_ACK);
    chk(o_port_status, 8'h84);
    cmd(CMD_UART);
    chk(o_port_status[ST_MODE], 1'b1);
    rd(v);
    chk(v, REPLY_ACK);
    cmd(CMD_VER);
    chk(o_port_status[ST_RX_EMPTY], 1'b1);
    // Traffic both ways while a reset command waits for the frames to end
    fork
      u_mdp_midi_dev.send_byte(rx_b);
      begin
        wr_burst(17);
        chk(o_port_status[ST_TX_FULL], 1'b1);
        cmd(CMD_RESET);
        cyc(100);
        chk(o_port_status[ST_MODE], 1'b1);
      end
    join
    for (int k = 0; k < 5000 && got_n == 0; k++)
      @(posedge i_clock);
    chk(got, tx_b[0]);
    chk(got_stop, 1'b1);
    cyc(2000);
    chk(o_port_status[ST_MODE], 1'b0);
    rd(v);
    chk(v, rx_b);
    // A serial byte into a full FIFO is lost and flags overrun; the flushed transmit FIFO stays silent
    for (int i = 0; i < 8; i++)
      cmd(CMD_VER);
    v = 8'h01;
    fork
      u_mdp_midi_dev.send_byte(rx_b);
      for (int k = 0; k < 40100; k++)
      begin
        cyc(1);
        v = v & 8'(ser_out);
      end
    join
    chk(v, 8'h01);
    cyc(10);
    chk(o_port_status, 8'h2C);
    @(posedge i_clock);
    i_stat_rd <= 1'b1;
    @(posedge i_clock);
    i_stat_rd <= 1'b0;
    cyc(3);
    chk(o_port_status[ST_OVERRUN], 1'b0);
    rd(v);
    chk(v, REPLY_ACK);
    // A legacy window forces the reset control value, so receive interrupts come back on
    @(posedge i_clock);
    i_port_control <= 8'h00;
    i_wide_window <= 1'b0;
    cyc(3);
    chk(o_irq, 1'b1);
    @(posedge i_clock);
    i_wide_window <= 1'b1;
    cyc(3);
    chk(o_irq, 1'b0);
    // Without the Pass-Thru FIFO, 3Fh drops the stored bytes and keeps only its acknowledge
    @(posedge i_clock);
    i_pt_fifo_en <= 1'b0;
    cmd(CMD_UART);
    chk(o_port_status[ST_MODE], 1'b1);
    rd(v);
    chk(v, REPLY_ACK);
    chk(o_port_status[ST_RX_EMPTY], 1'b1);
    final_report();
  end
endmodule : midi_serial_port_test
